// ### design/dscd_top.sv
`timescale 1ns/10ps
`include "dscd_defs.svh"

// Summary of operation
// - Word: four control, ten data, two ignored
// - Early deselect discards the partial word
// - Code one, first bit zero clears registers
// - Code one, first bit one presets ones
// - Codes two to nine load one input
// - Four-channel: channels four-seven loads ignored
// - Code A writes through channels 0-3
// - Code B writes through channels 4-7
// - Code C writes through all channels
// - Code D loads all input registers only
// - Code E copies masked inputs to outputs
// - Four-channel: upper mask bits are ignored
module dscd_top #(
    parameter int NUM_CHAN = 8
) (
    // Clock and reset
    input  wire logic                               I_MCLK,
    input  wire logic                               I_RST_N,
    // Serial port
    input  wire logic                               I_CS_N,
    input  wire logic                               I_SCLK,
    input  wire logic                               I_DIN,
    output logic                                    O_DOUT,
    // General-purpose pin states
    input  wire logic [3:0]                         I_GPIO,
    // Channel registers
    output dscd_pkg::dscd_code_t [NUM_CHAN-1:0]     O_INPUT_CODE,
    output dscd_pkg::dscd_code_t [NUM_CHAN-1:0]     O_DAC_CODE,
    output logic                                    O_WORD_STB
);
    import dscd_pkg::*;

    typedef struct packed {
        dscd_code_t [NUM_CHAN-1:0] inr;
        dscd_code_t [NUM_CHAN-1:0] dacr;
    } dscd_bank_s;

    dscd_word_if   word_if ();
    dscd_bank_s    q;
    dscd_bank_s    d;
    logic [3:0]    ctrl;
    dscd_code_t    data;
    logic          wv;
    logic [NUM_CHAN-1:0] sel_in;
    logic [NUM_CHAN-1:0] sel_dac;
    logic [NUM_CHAN-1:0] sel_xfer;

    // ======================================================================
    // Serial front end
    // ======================================================================
    // Host is expected to send the select byte first; others except the pin read command are skipped
    dscd_shifter u_shift (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RST_N),
        .i_cs_n  (I_CS_N),
        .i_sclk  (I_SCLK),
        .i_din   (I_DIN),
        .o_dout  (O_DOUT),
        .i_gpio  (I_GPIO),
        .word_if (word_if)
    );

    // Field split; the two sub-bits are never looked at
    assign wv   = word_if.word_v;
    assign ctrl = word_if.word[`DSCD_CTRL_HI:`DSCD_CTRL_LO];
    assign data = word_if.word[`DSCD_DATA_HI:`DSCD_DATA_LO];

    // ======================================================================
    // Per-channel decode
    // ======================================================================
    // Channels that do not exist are never built, so codes aimed at them fall idle
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_ch
        localparam logic LO = (i < `DSCD_LO_GROUP);
        // Input register targets
        assign sel_in[i] = wv & ((ctrl == 4'(`DSCD_C_LOAD0 + i))
                               | ((ctrl == `DSCD_C_THRU_LO) & LO)
                               | ((ctrl == `DSCD_C_THRU_HI) & !LO)
                               | (ctrl == `DSCD_C_THRU_ALL)
                               | (ctrl == `DSCD_C_LOAD_ALL));
        // Write-through targets
        assign sel_dac[i] = wv & (((ctrl == `DSCD_C_THRU_LO) & LO)
                                | ((ctrl == `DSCD_C_THRU_HI) & !LO)
                                | (ctrl == `DSCD_C_THRU_ALL));
        // Mask bit i sits above the low two data bits, channel 7 highest
        assign sel_xfer[i] = wv & (ctrl == `DSCD_C_XFER)
                           & data[i+`DSCD_MASK_LO];
    end

    // ======================================================================
    // Register bank
    // ======================================================================
    // Reset and preset hit both banks; nothing selected means a no-op
    always_comb begin
        d = q;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (wv && ctrl == `DSCD_C_RESET) begin
                d.inr[i]  = data[`DSCD_CODE_W-1] ? `DSCD_CODE_ONES : `DSCD_CODE_ZERO;
                d.dacr[i] = data[`DSCD_CODE_W-1] ? `DSCD_CODE_ONES : `DSCD_CODE_ZERO;
            end else begin
                if (sel_in[i]) begin
                    d.inr[i] = data;
                end
                if (sel_dac[i]) begin
                    d.dacr[i] = data;
                end else if (sel_xfer[i]) begin
                    // Copies the value held before this word, a software load strobe
                    d.dacr[i] = q.inr[i];
                end
            end
        end
    end

    // Bank registers
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs from flops
    assign O_INPUT_CODE = q.inr;
    assign O_DAC_CODE   = q.dacr;
    assign O_WORD_STB   = wv;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    nop_hold_a: assert property (wv && ctrl == `DSCD_C_NOP |=> $stable(q))
        else $error("no-op word changed a register");
    clear_all_a: assert property (wv && ctrl == `DSCD_C_RESET && !data[9]
                                  |=> q == '0)
        else $error("clear did not zero registers");
    preset_all_a: assert property (wv && ctrl == `DSCD_C_RESET && data[9]
                                   |=> q.dacr[0] == `DSCD_CODE_ONES
                                   && q.inr[NUM_CHAN-1] == `DSCD_CODE_ONES)
        else $error("preset did not set ones");
    single_load_a: assert property (wv && ctrl == `DSCD_C_LOAD0
                                    |=> q.inr[0] == $past(data) && $stable(q.dacr))
        else $error("single load wrong");
    upper_idle_a: assert property (wv && NUM_CHAN == 4 && ctrl >= 4'h6 && ctrl <= 4'h9
                                   |=> $stable(q))
        else $error("absent channel load changed state");
    thru_low_a: assert property (wv && ctrl == `DSCD_C_THRU_LO
                                 |=> q.dacr[0] == $past(data) && q.inr[3] == $past(data))
        else $error("low write-through wrong");
    thru_high_a: assert property (wv && ctrl == `DSCD_C_THRU_HI
                                  |=> (NUM_CHAN == 4) ? $stable(q)
                                   : q.dacr[NUM_CHAN-1] == $past(data))
        else $error("high write-through wrong");
    thru_all_a: assert property (wv && ctrl == `DSCD_C_THRU_ALL
                                 |=> q.dacr[0] == $past(data)
                                 && q.dacr[NUM_CHAN-1] == $past(data))
        else $error("broadcast write-through wrong");
    load_all_a: assert property (wv && ctrl == `DSCD_C_LOAD_ALL
                                 |=> q.inr[NUM_CHAN-1] == $past(data) && $stable(q.dacr))
        else $error("broadcast load wrong");
    mask_xfer_a: assert property (wv && ctrl == `DSCD_C_XFER
                                  |=> q.dacr[0] == ($past(data[2]) ? $past(q.inr[0])
                                                   : $past(q.dacr[0]))
                                  && $stable(q.inr))
        else $error("masked transfer wrong");

    // ======================================================================
    // Per-channel checks
    // ======================================================================
    // The checks above test loaded values only on end channels, save the whole-bank no-op, clear and idle checks; these cover every built one
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chk
        localparam logic LOW = (i < `DSCD_LO_GROUP);

        // Between words the bank must hold still, so a cut frame leaves no trace
        in_quiet_a: assert property (!wv |=> $stable(q.inr[i]))
            else $error("input register moved without a word");
        dac_quiet_a: assert property (!wv |=> $stable(q.dacr[i]))
            else $error("DAC register moved without a word");
        // Clear and preset reach both registers of every channel
        chan_preset_a: assert property (wv && ctrl == `DSCD_C_RESET
            |=> q.inr[i] == {`DSCD_CODE_W{$past(data[9])}} && q.dacr[i] == q.inr[i])
            else $error("channel clear or preset wrong");
        // A single load lands only in its own input register
        own_load_a: assert property (wv && ctrl == 4'(`DSCD_C_LOAD0 + i)
            |=> q.inr[i] == $past(data) && $stable(q.dacr[i]))
            else $error("single load missed its channel");
        other_load_a: assert property (wv && ctrl >= `DSCD_C_LOAD0
            && ctrl < `DSCD_C_THRU_LO && ctrl != 4'(`DSCD_C_LOAD0 + i)
            |=> $stable(q.inr[i]))
            else $error("single load hit another channel");
        // Write-through picks its group by channel number, broadcast takes all
        thru_chan_a: assert property (wv
            && (ctrl == `DSCD_C_THRU_ALL || ctrl == (LOW ? `DSCD_C_THRU_LO : `DSCD_C_THRU_HI))
            |=> q.inr[i] == $past(data) && q.dacr[i] == $past(data))
            else $error("write-through missed a channel");
        thru_skip_a: assert property (wv
            && ctrl == (LOW ? `DSCD_C_THRU_HI : `DSCD_C_THRU_LO)
            |=> $stable(q.inr[i]) && $stable(q.dacr[i]))
            else $error("write-through hit a wrong channel");
        // Broadcast load leaves the DAC side alone
        bcast_load_a: assert property (wv && ctrl == `DSCD_C_LOAD_ALL
            |=> q.inr[i] == $past(data) && $stable(q.dacr[i]))
            else $error("broadcast load wrong on a channel");
        // Transfer copies the old input value only where the mask bit is set
        xfer_chan_a: assert property (wv && ctrl == `DSCD_C_XFER
            |=> q.dacr[i] == ($past(data[i+`DSCD_MASK_LO]) ? $past(q.inr[i])
                                                            : $past(q.dacr[i])))
            else $error("masked transfer wrong on a channel");
    end

    nop_seen_c:  cover property (wv && ctrl == `DSCD_C_NOP);
    thru_seen_c: cover property (wv && ctrl == `DSCD_C_THRU_ALL);
    xfer_seen_c: cover property (wv && ctrl == `DSCD_C_XFER && data[9:2] != 8'h00);
endmodule

// ### design/dscd_defs.svh
`ifndef DSCD_DEFS_SVH
`define DSCD_DEFS_SVH

// ==========================================================================
// Serial framing
// ==========================================================================
`define DSCD_CMD_BITS      5'd8
`define DSCD_WORD_BITS     5'd16
`define DSCD_RD_BITS       5'd8
`define DSCD_SEL_DAC       4'h1
`define DSCD_CMD_GPIO_RD   8'h01

// ==========================================================================
// Word layout: control nibble, ten data bits, two ignored sub-bits
// ==========================================================================
`define DSCD_CTRL_HI       15
`define DSCD_CTRL_LO       12
`define DSCD_DATA_HI       11
`define DSCD_DATA_LO       2
`define DSCD_CODE_W        10
`define DSCD_MASK_LO       2

// ==========================================================================
// Control codes
// ==========================================================================
`define DSCD_C_NOP         4'h0
`define DSCD_C_RESET       4'h1
`define DSCD_C_LOAD0       4'h2
`define DSCD_C_THRU_LO     4'hA
`define DSCD_C_THRU_HI     4'hB
`define DSCD_C_THRU_ALL    4'hC
`define DSCD_C_LOAD_ALL    4'hD
`define DSCD_C_XFER        4'hE

// ==========================================================================
// Reset values
// ==========================================================================
`define DSCD_CODE_ZERO     10'h000
`define DSCD_CODE_ONES     10'h3FF
`define DSCD_LO_GROUP      4

`endif

// ### design/dscd_pkg.sv
`include "dscd_defs.svh"

package dscd_pkg;

    // ======================================================================
    // Types
    // ======================================================================
    typedef logic [`DSCD_CODE_W-1:0] dscd_code_t;

    typedef enum logic [1:0] {
        DSCD_CMD,
        DSCD_DACW,
        DSCD_GPRD,
        DSCD_SKIP
    } dscd_state_e;

    typedef struct packed {
        dscd_state_e st;
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic [3:0]  snap;
        logic        dout;
        logic        sclk;
        logic        wv;
    } dscd_shift_s;

endpackage

// ### design/dscd_word_if.sv
`timescale 1ns/10ps

// Complete serial word handed from the front end to the decoder
interface dscd_word_if;
    logic        word_v;
    logic [15:0] word;

    modport src (output word_v, output word);
    modport dst (input word_v, input word);
endinterface

// ### design/dscd_shifter.sv
`timescale 1ns/10ps
`include "dscd_defs.svh"

module dscd_shifter (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Serial port
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic        i_din,
    output logic             o_dout,
    // Pin states for read-back
    input  wire logic [3:0]  i_gpio,
    // Finished word
    dscd_word_if.src         word_if
);
    import dscd_pkg::*;

    dscd_shift_s q;
    dscd_shift_s d;
    logic        fall;
    logic [7:0]  cmd;
    logic [2:0]  pos;

    // ======================================================================
    // Frame sequencer
    // ======================================================================
    // Data is taken on the serial clock falling edge, seen through the prior sample
    always_comb begin
        d      = q;
        d.wv   = 1'b0;
        d.sclk = i_sclk;
        fall   = q.sclk & ~i_sclk;
        cmd    = {q.sh[6:0], i_din};
        pos    = q.cnt[2:0] + 3'h1;
        if (i_cs_n) begin
            // Deselect drops any partial word without a pulse
            d.st   = DSCD_CMD;
            d.cnt  = 5'd0;
            d.dout = 1'b0;
        end else if (fall) begin
            case (q.st)
                DSCD_CMD: begin
                    d.sh  = {q.sh[14:0], i_din};
                    d.cnt = q.cnt + 5'd1;
                    if (q.cnt == `DSCD_CMD_BITS - 5'd1) begin
                        d.cnt = 5'd0;
                        if (cmd[7:4] == `DSCD_SEL_DAC) begin
                            d.st = DSCD_DACW;
                        end else if (cmd == `DSCD_CMD_GPIO_RD) begin
                            d.st   = DSCD_GPRD;
                            d.snap = i_gpio; // Freeze pins so the byte is coherent
                            d.dout = 1'b0;
                        end else begin
                            d.st = DSCD_SKIP;
                        end
                    end
                end
                DSCD_DACW: begin
                    d.sh = {q.sh[14:0], i_din};
                    if (q.cnt == `DSCD_WORD_BITS - 5'd1) begin
                        d.wv = 1'b1;
                        d.st = DSCD_SKIP;
                    end else begin
                        d.cnt = q.cnt + 5'd1;
                    end
                end
                DSCD_GPRD: begin
                    if (q.cnt == `DSCD_RD_BITS - 5'd1) begin
                        d.st   = DSCD_SKIP;
                        d.dout = 1'b0;
                    end else begin
                        d.cnt  = q.cnt + 5'd1;
                        // Four leading zeros, then port C pin 1 down to port A pin 0
                        d.dout = pos[2] & q.snap[~pos[1:0]];
                    end
                end
                DSCD_SKIP: begin
                    d.dout = 1'b0;
                end
                default: begin
                    d.st = DSCD_SKIP;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{st: DSCD_CMD, cnt: 5'd0, sh: 16'h0000, snap: 4'h0,
                   dout: 1'b0, sclk: 1'b0, wv: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign o_dout         = q.dout;
    assign word_if.word_v = q.wv;
    assign word_if.word   = q.sh;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    partial_drop_a: assert property (i_cs_n |=> !q.wv)
        else $error("word issued after deselect");
    read_zeros_a: assert property ((q.st == DSCD_GPRD) && (q.cnt < 5'd4) |-> !q.dout)
        else $error("read-back leading bit not zero");
    read_first_a: assert property ((q.st == DSCD_GPRD) && (q.cnt == 5'd4)
                                   |-> q.dout == q.snap[3])
        else $error("read-back first pin bit wrong");
    word_len_a: assert property (q.wv |-> $past(q.st) == DSCD_DACW
                                 && $past(q.cnt) == 5'd15)
        else $error("word issued at wrong bit count");

    read_seen_c: cover property ((q.st == DSCD_GPRD) ##1 (q.st == DSCD_SKIP));
    word_seen_c: cover property (q.wv);
endmodule

// ### verification/dscd_spi_host.sv
`timescale 1ns/10ps

// ==========================================================================
// Serial host model
// ==========================================================================
module dscd_spi_host (
    // Clock
    input  wire logic       i_clk,
    // Serial port
    output logic            o_cs_n,
    output logic            o_sclk,
    output logic            o_din,
    input  wire logic       i_dout,
    // Captured read-back byte
    output logic            o_rd_v,
    output logic [7:0]      o_rd_byte
);
    // Clock parked high between frames so no stray fall is ever seen
    initial begin
        o_cs_n    = 1'b1;
        o_sclk    = 1'b1;
        o_din     = 1'b0;
        o_rd_v    = 1'b0;
        o_rd_byte = 8'h00;
    end

    // One frame: command byte then word or read bits, MSB first; nb below 24 cuts a word frame short
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] w, input int nb);
        logic [23:0] b;
        b = {cmd, w};
        o_cs_n = 1'b0;
        repeat (2) @(negedge i_clk);
        for (int k = 0; k < nb; k++) begin
            o_din  = b[23-k];
            o_sclk = 1'b0;
            repeat (2) @(negedge i_clk);
            // Read-back bit is sampled late in the low phase, long after it settled
            if (k >= 7 && k < 15) o_rd_byte[14-k] = i_dout;
            o_sclk = 1'b1;
            repeat (2) @(negedge i_clk);
        end
        // Released data line shows the opposite level, never a stale bit
        o_cs_n = 1'b1;
        o_din  = ~o_din;
        @(negedge i_clk);
        if (cmd == 8'h01 && nb == 16) begin
            o_rd_v = 1'b1;
            @(negedge i_clk);
            o_rd_v = 1'b0;
        end
    endtask
endmodule

// ### verification/dscd_top_tb.sv
`timescale 1ns/10ps

// ==========================================================================
// Self-checking bench: an eight- and a four-channel device share one host
// ==========================================================================
module dscd_top_tb;
    import dscd_pkg::*;

    typedef struct packed {
        logic [1:0][7:0][9:0] i;
        logic [1:0][7:0][9:0] d;
    } dscd_exp_s;

    logic                 clk = 1'b0;
    logic                 rst_n;
    logic                 cs_n;
    logic                 sclk;
    logic                 din;
    logic                 dout;
    logic                 rd_v;
    logic [7:0]           rd_byte;
    logic [3:0]           gpio;
    dscd_code_t [7:0]     in8;
    dscd_code_t [7:0]     dac8;
    dscd_code_t [3:0]     in4;
    dscd_code_t [3:0]     dac4;
    logic                 stb;
    logic [1:0][7:0][9:0] mi = '0;
    logic [1:0][7:0][9:0] md = '0;
    dscd_exp_s            e;
    dscd_exp_s            wq[$];
    logic [7:0]           rq[$];
    logic [31:0]          seed;
    logic [15:0]          w;
    int                   n_errors = 0;
    int                   n_tests = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    dscd_spi_host host_u (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din),
                          .i_dout(dout), .o_rd_v(rd_v), .o_rd_byte(rd_byte));

    dscd_top #(.NUM_CHAN(8)) dut_u (.I_MCLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n),
        .I_SCLK(sclk), .I_DIN(din), .O_DOUT(dout), .I_GPIO(gpio),
        .O_INPUT_CODE(in8), .O_DAC_CODE(dac8), .O_WORD_STB(stb));

    // Four-channel variant only listens; its read-back pin is left open
    dscd_top #(.NUM_CHAN(4)) dut4_u (.I_MCLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n),
        .I_SCLK(sclk), .I_DIN(din), .O_DOUT(), .I_GPIO(gpio),
        .O_INPUT_CODE(in4), .O_DAC_CODE(dac4), .O_WORD_STB());

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Reference register model for both variants; result noted in the queue
    task automatic apply(input logic [15:0] wd);
        logic [3:0] c;
        logic [9:0] d;
        int         n;
        c = wd[15:12];
        d = wd[11:2];
        for (int v = 0; v < 2; v++) begin
            n = v ? 4 : 8;
            for (int i = 0; i < n; i++) begin
                case (c)
                    4'h1: begin
                        mi[v][i] = d[9] ? 10'h3FF : 10'h000;
                        md[v][i] = mi[v][i];
                    end
                    4'hA, 4'hB, 4'hC: if (c == 4'hC || (c == 4'hA) == (i < 4)) begin
                        mi[v][i] = d;
                        md[v][i] = d;
                    end
                    4'hD: mi[v][i] = d;
                    4'hE: if (d[i+2]) md[v][i] = mi[v][i];
                    default: if (c >= 4'h2 && c <= 4'h9 && i == c - 2) mi[v][i] = d;
                endcase
            end
        end
        wq.push_back({mi, md});
    endtask

    // Word monitor: strobe seen mid-cycle, so no race with the edge that launches it;
    // the bank has settled by the next falling edge
    always @(negedge clk) begin
        if (stb === 1'b1) begin
            @(negedge clk);
            e = wq.pop_front();
            check(in8, e.i[0]);
            check(dac8, e.d[0]);
            check({40'h0, in4}, {40'h0, e.i[1][3:0]});
            check({40'h0, dac4}, {40'h0, e.d[1][3:0]});
        end
    end

    // Read-back monitor
    always @(posedge clk) begin
        if (rd_v === 1'b1) check({72'h0, rd_byte}, {72'h0, rq.pop_front()});
    end

    // Watchdog, well beyond the few thousand cycles the sequence needs
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        gpio  = 4'h0;
        seed  = 32'd29230;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        // Every control code three times, clear and preset both reached
        for (int p = 0; p < 3; p++) begin
            for (int c = 0; c < 16; c++) begin
                seed = xs(seed);
                w = {c[3:0], seed[11:0]};
                if (c == 1) w[11] = p[0];
                apply(w);
                host_u.xfer({4'h1, seed[15:12]}, w, 24);
            end
        end
        // Deselect one bit early, then a foreign select byte: neither may land
        seed = xs(seed);
        host_u.xfer(8'h10, {4'hC, seed[11:0]}, 23);
        host_u.xfer(8'h20, {4'hC, seed[11:0]}, 24);
        apply({4'h0, seed[11:0]});
        host_u.xfer(8'h1F, {4'h0, seed[11:0]}, 24);
        // Pin read-back with random pin states
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            gpio = seed[3:0];
            rq.push_back({4'h0, seed[3:0]});
            host_u.xfer(8'h01, seed[31:16], 16);
        end
        repeat (4) @(negedge clk);
        // Nothing may remain pending: a missing strobe leaves a note behind
        check(80'(wq.size() + rq.size()), 80'h0);
        end_sim();
    end
endmodule
